// [hw/cmpone_pkg.sv]
// Purpose: Constants for the comparator one control register bank
// Assumes: 8-bit special-function register port, page 0x0
// Notes: Offsets are the printed special-function addresses
package cmpone_pkg;
  localparam logic [7:0] CMPONE_CTRL_ADDR = 8'h9a;
  localparam logic [7:0] CMPONE_MODE_ADDR = 8'h9c;
  localparam logic [3:0] CMPONE_PAGE = 4'h0;
  localparam int CMPONE_EN_BIT = 7;
  localparam int CMPONE_RES_BIT = 6;
  localparam int CMPONE_RISE_BIT = 5;
  localparam int CMPONE_FALL_BIT = 4;
  localparam int CMPONE_HYP_LSB = 2;
  localparam int CMPONE_HYN_LSB = 0;
  localparam int CMPONE_RIE_BIT = 5;
  localparam int CMPONE_FIE_BIT = 4;
  localparam int CMPONE_MD_LSB = 0;
  localparam logic [7:0] CMPONE_CTRL_RST = 8'h00;
  localparam logic [1:0] CMPONE_MD_RST = 2'h2;
  localparam logic [1:0] CMPONE_RIE_FIE_RST = 2'h0;
  localparam logic [7:0] CMPONE_MODE_FIXED = 8'h80;
  localparam int CMPONE_SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    CMPONE_TMR_A = 2'h1,
    CMPONE_TMR_B = 2'h2
  } cmpone_tmr_e;
endpackage : cmpone_pkg

// [hw/cmpone_sync.sv]
// Purpose: Synchroniser for the asynchronous comparator result
// Assumes: Single clock domain, synchronous active-high reset
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
module cmpone_sync #(
  parameter int STAGES = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic [STAGES-1:0] sync_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_q <= '0;
    end else begin
      sync_q <= {sync_q[STAGES-2:0], din};
    end
  end

  assign dout = sync_q[STAGES-1];
endmodule : cmpone_sync

// [hw/cmpone_regs.sv]
// Purpose: Control and status registers of comparator one
// Assumes: 8-bit SFR bus; sfr_wr/sfr_rd are one-cycle strobes
// Notes: Edge flags are set by hardware, cleared by software
// Functional notes
// (RULE1) Control at 0x9a page 0; bit7 enables
// (RULE2) Bit 6 read-only comparator result
// (RULE3) Bit 5 sticky rising flag, software clears
// (RULE4) Bit 4 sticky falling flag, software clears
// (RULE5) Bits 3:2 positive hysteresis select
// (RULE6) Bits 1:0 negative hysteresis select
// (RULE7) Mode field selects speed/power tradeoff
// (RULE8) Mode bits 3:2 read zero
// (RULE9) Result routable to either of two timers
// (RULE10) Software sets input pins analog
// (RULE11) Software makes crossbar skip input pins
// (RULE12) Edge enables gate interrupt; bit7=1 bit6=0
`timescale 1ns/1ps
module cmpone_regs
  import cmpone_pkg::*;
#(
  parameter int SYNC_STAGES = CMPONE_SYNC_STAGES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic [3:0] sfr_page,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic cmp_raw,
  input wire logic [1:0] timer_route_sel,
  output logic cmp_enable,
  output logic [1:0] pos_hyst_sel,
  output logic [1:0] neg_hyst_sel,
  output logic [1:0] speed_power_sel,
  output logic cmp_irq,
  output logic timer_a_capture,
  output logic timer_b_capture
);
  logic cmp_sync;
  logic res_q;
  logic en_q;
  logic rise_q;
  logic fall_q;
  logic [1:0] hyp_q;
  logic [1:0] hyn_q;
  logic rie_q;
  logic fie_q;
  logic [1:0] md_q;
  logic [7:0] rdata_q;
  logic cap_a_q;
  logic cap_b_q;
  logic page_ok;
  logic ctrl_wr;
  logic mode_wr;
  logic rise_ev;
  logic fall_ev;
  logic [7:0] ctrl_val;
  logic [7:0] mode_val;

  // Costs two cycles of latency, but keeps a metastable level out of the edge logic
  cmpone_sync #(
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .din(cmp_raw),
    .dout(cmp_sync)
  );

  assign page_ok = (sfr_page == CMPONE_PAGE);
  assign ctrl_wr = sfr_wr && page_ok && (sfr_addr == CMPONE_CTRL_ADDR); // RULE1
  assign mode_wr = sfr_wr && page_ok && (sfr_addr == CMPONE_MODE_ADDR);

  // Disabled comparator reads low and makes no edges
  always_ff @(posedge clk) begin
    if (rst) begin
      res_q <= 1'b0;
    end else begin
      res_q <= cmp_sync & en_q; // RULE2
    end
  end

  assign rise_ev = en_q && cmp_sync && !res_q;
  assign fall_ev = en_q && !cmp_sync && res_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      en_q <= CMPONE_CTRL_RST[CMPONE_EN_BIT];
      hyp_q <= CMPONE_CTRL_RST[CMPONE_HYP_LSB +: 2];
      hyn_q <= CMPONE_CTRL_RST[CMPONE_HYN_LSB +: 2];
    end else if (ctrl_wr) begin
      en_q <= sfr_wdata[CMPONE_EN_BIT]; // RULE1
      hyp_q <= sfr_wdata[CMPONE_HYP_LSB +: 2]; // RULE5
      hyn_q <= sfr_wdata[CMPONE_HYN_LSB +: 2]; // RULE6
    end
  end

  // Set wins over a simultaneous software clear so no edge is lost
  always_ff @(posedge clk) begin
    if (rst) begin
      rise_q <= CMPONE_CTRL_RST[CMPONE_RISE_BIT];
      fall_q <= CMPONE_CTRL_RST[CMPONE_FALL_BIT];
    end else begin
      if (rise_ev) begin
        rise_q <= 1'b1; // RULE3
      end else if (ctrl_wr) begin
        rise_q <= sfr_wdata[CMPONE_RISE_BIT]; // RULE3
      end
      if (fall_ev) begin
        fall_q <= 1'b1; // RULE4
      end else if (ctrl_wr) begin
        fall_q <= sfr_wdata[CMPONE_FALL_BIT]; // RULE4
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rie_q <= CMPONE_RIE_FIE_RST[1];
      fie_q <= CMPONE_RIE_FIE_RST[0];
      md_q <= CMPONE_MD_RST;
    end else if (mode_wr) begin
      rie_q <= sfr_wdata[CMPONE_RIE_BIT]; // RULE12
      fie_q <= sfr_wdata[CMPONE_FIE_BIT]; // RULE12
      md_q <= sfr_wdata[CMPONE_MD_LSB +: 2]; // RULE7
    end
  end

  assign ctrl_val = {en_q, res_q, rise_q, fall_q, hyp_q, hyn_q};
  // Bits 7 and 6 fixed, bits 3:2 always zero
  assign mode_val = CMPONE_MODE_FIXED | {2'h0, rie_q, fie_q, 2'h0, md_q}; // RULE8 RULE12

  // Unselected reads return zero so several banks can share one read path
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (sfr_rd && page_ok && sfr_addr == CMPONE_CTRL_ADDR) begin
      rdata_q <= ctrl_val;
    end else if (sfr_rd && page_ok && sfr_addr == CMPONE_MODE_ADDR) begin
      rdata_q <= mode_val;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Capture pulse on any result edge, sent to the selected timer
  // Both timers take the same pulse when both select bits are set
  always_ff @(posedge clk) begin
    if (rst) begin
      cap_a_q <= 1'b0;
      cap_b_q <= 1'b0;
    end else begin
      cap_a_q <= (rise_ev || fall_ev) && timer_route_sel[0]; // RULE9
      cap_b_q <= (rise_ev || fall_ev) && timer_route_sel[1]; // RULE9
    end
  end

  assign sfr_rdata = rdata_q;
  assign cmp_enable = en_q;
  assign pos_hyst_sel = hyp_q;
  assign neg_hyst_sel = hyn_q;
  assign speed_power_sel = md_q;
  assign cmp_irq = (rise_q && rie_q) || (fall_q && fie_q); // RULE12
  assign timer_a_capture = cap_a_q;
  assign timer_b_capture = cap_b_q;

  chk_rise_sets: assert property (@(posedge clk) disable iff (rst)
    rise_ev |=> rise_q) else $error("rise flag not set"); // RULE3
  chk_fall_sets: assert property (@(posedge clk) disable iff (rst)
    fall_ev |=> fall_q) else $error("fall flag not set"); // RULE4
  chk_rise_sticky: assert property (@(posedge clk) disable iff (rst)
    rise_q && !ctrl_wr |=> rise_q) else $error("rise flag dropped"); // RULE3
  chk_fall_sticky: assert property (@(posedge clk) disable iff (rst)
    fall_q && !ctrl_wr |=> fall_q) else $error("fall flag dropped"); // RULE4
  chk_enable_write: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr |=> cmp_enable == $past(sfr_wdata[7])) else $error("enable not stored"); // RULE1
  chk_hyst_write: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr |=> pos_hyst_sel == $past(sfr_wdata[3:2]) && neg_hyst_sel == $past(sfr_wdata[1:0]))
    else $error("hysteresis not stored"); // RULE5
  chk_mode_read: assert property (@(posedge clk) disable iff (rst)
    sfr_rd && page_ok && sfr_addr == CMPONE_MODE_ADDR |=> sfr_rdata[7:6] == 2'b10 && sfr_rdata[3:2] == 2'b00)
    else $error("mode fixed bits wrong"); // RULE8
  chk_result_read: assert property (@(posedge clk) disable iff (rst)
    sfr_rd && page_ok && sfr_addr == CMPONE_CTRL_ADDR |=> sfr_rdata[6] == $past(res_q))
    else $error("result bit wrong"); // RULE2
  chk_mode_write: assert property (@(posedge clk) disable iff (rst)
    mode_wr |=> speed_power_sel == $past(sfr_wdata[1:0])) else $error("mode not stored"); // RULE7
  chk_irq_gate: assert property (@(posedge clk) disable iff (rst)
    rise_q && !rie_q && !(fall_q && fie_q) |-> !cmp_irq) else $error("irq not gated"); // RULE12
  chk_route: assert property (@(posedge clk) disable iff (rst)
    rise_ev && timer_route_sel == 2'b01 |=> timer_a_capture && !timer_b_capture)
    else $error("capture misrouted"); // RULE9

  // Edge to interrupt, flag clear and disabled result
  chk_irq_rise: assert property (@(posedge clk) disable iff (rst)
    rise_ev && rie_q && !mode_wr |=> cmp_irq) else $error("rise irq missing"); // RULE12
  chk_irq_fall: assert property (@(posedge clk) disable iff (rst)
    fall_ev && fie_q && !mode_wr |=> cmp_irq) else $error("fall irq missing"); // RULE12
  chk_rise_clear: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr && !rise_ev && !sfr_wdata[CMPONE_RISE_BIT] |=> !rise_q) else $error("rise flag not cleared"); // RULE3
  chk_fall_clear: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr && !fall_ev && !sfr_wdata[CMPONE_FALL_BIT] |=> !fall_q) else $error("fall flag not cleared"); // RULE4
  chk_off_low: assert property (@(posedge clk) disable iff (rst)
    !en_q |=> !res_q) else $error("result high while disabled"); // RULE2
  chk_bad_read: assert property (@(posedge clk) disable iff (rst)
    sfr_rd && !page_ok |=> sfr_rdata == 8'h00) else $error("foreign page read not zero"); // RULE1
  chk_enables_write: assert property (@(posedge clk) disable iff (rst)
    mode_wr |=> rise_q == rise_q && rie_q == $past(sfr_wdata[5]) && fie_q == $past(sfr_wdata[4]))
    else $error("edge enables not stored"); // RULE12
  // Routing and read-back checks
  chk_route_b: assert property (@(posedge clk) disable iff (rst)
    fall_ev && timer_route_sel == 2'b10 |=> timer_b_capture && !timer_a_capture)
    else $error("capture misrouted to timer a"); // RULE9
  chk_ctrl_read: assert property (@(posedge clk) disable iff (rst)
    sfr_rd && page_ok && sfr_addr == CMPONE_CTRL_ADDR |=> sfr_rdata[7] == $past(en_q) && sfr_rdata[5] == $past(rise_q))
    else $error("control read wrong"); // RULE1 RULE3

  cov_rise: cover property (@(posedge clk) disable iff (rst) rise_ev);
  cov_fall: cover property (@(posedge clk) disable iff (rst) fall_ev);
  cov_irq: cover property (@(posedge clk) disable iff (rst) cmp_irq);
  cov_clear_race: cover property (@(posedge clk) disable iff (rst) rise_ev && ctrl_wr);
  cov_route_b: cover property (@(posedge clk) disable iff (rst) timer_b_capture);
endmodule : cmpone_regs

// [tb/comparator_one_control_regs_tb.sv]
// Purpose: Self-checking bench for the comparator one register bank
// Assumes: Inputs change at the falling edge; read data is valid one cycle after the strobe
// Notes: Result waits of eight and twenty cycles cover the two-stage input synchroniser
`timescale 1ns/1ps
module comparator_one_control_regs_tb
  import cmpone_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [3:0] sfr_page = 4'h0;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic cmp_raw = 1'b0;
  logic [1:0] timer_route_sel = 2'h0;
  logic cmp_enable, cmp_irq, timer_a_capture, timer_b_capture;
  logic [1:0] pos_hyst_sel, neg_hyst_sel, speed_power_sel;
  logic [7:0] v;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int cap_a = 0;
  int cap_b = 0;
  always #2.5 clk = ~clk;
  cmpone_regs uut (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .cmp_raw(cmp_raw),
    .timer_route_sel(timer_route_sel), .cmp_enable(cmp_enable), .pos_hyst_sel(pos_hyst_sel),
    .neg_hyst_sel(neg_hyst_sel), .speed_power_sel(speed_power_sel), .cmp_irq(cmp_irq),
    .timer_a_capture(timer_a_capture), .timer_b_capture(timer_b_capture));
  task automatic stop_test();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // Ceiling well above the hundred or so cycles the tests need
  // Capture pulses counted mid-cycle, where they have settled
  always @(negedge clk) begin
    if (timer_a_capture === 1'b1) cap_a++;
    if (timer_b_capture === 1'b1) cap_b++;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] p);
    @(negedge clk);
    sfr_addr = a;
    sfr_page = p;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [3:0] p, output logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_page = p;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask : rd
  task automatic t_reset();
    rd(CMPONE_CTRL_ADDR, CMPONE_PAGE, v);
    chk(v, 8'h00);
    rd(CMPONE_MODE_ADDR, CMPONE_PAGE, v);
    chk(v, 8'h82);
    chk({6'h00, speed_power_sel}, 8'h02);
    $display("test reset done");
  endtask : t_reset
  task automatic t_hyst();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      // Bit 6 written high must not stick
      wr(CMPONE_CTRL_ADDR, {2'b11, 2'b00, c, ~c}, CMPONE_PAGE);
      chk({3'h0, cmp_enable, pos_hyst_sel, neg_hyst_sel}, {4'h1, c, ~c});
      rd(CMPONE_CTRL_ADDR, CMPONE_PAGE, v);
      chk(v, {4'h8, c, ~c});
    end
    wr(CMPONE_CTRL_ADDR, 8'h00, CMPONE_PAGE);
    chk({7'h00, cmp_enable}, 8'h00);
    $display("test hyst done");
  endtask : t_hyst
  task automatic t_mode();
    for (int i = 0; i < 4; i++) begin
      wr(CMPONE_MODE_ADDR, 8'hcc | 8'(i), CMPONE_PAGE);
      chk({6'h00, speed_power_sel}, 8'(i));
      rd(CMPONE_MODE_ADDR, CMPONE_PAGE, v);
      chk(v, 8'h80 | 8'(i));
    end
    $display("test mode done");
  endtask : t_mode
  task automatic t_bad();
    wr(CMPONE_CTRL_ADDR, 8'h8f, 4'h1);
    rd(CMPONE_CTRL_ADDR, CMPONE_PAGE, v);
    chk(v, 8'h00);
    rd(8'h9b, CMPONE_PAGE, v);
    chk(v, 8'h00);
    rd(CMPONE_CTRL_ADDR, 4'h1, v);
    chk(v, 8'h00);
    $display("test bad access done");
  endtask : t_bad
  task automatic t_edge();
    wr(CMPONE_MODE_ADDR, 8'ha2, CMPONE_PAGE);
    wr(CMPONE_CTRL_ADDR, 8'h80, CMPONE_PAGE);
    timer_route_sel = 2'h1;
    cap_a = 0;
    cap_b = 0;
    cmp_raw = 1'b1;
    repeat (8) @(negedge clk);
    chk({7'h00, cmp_irq}, 8'h01);
    chk(8'(cap_a * 16 + cap_b), 8'h10);
    rd(CMPONE_CTRL_ADDR, CMPONE_PAGE, v);
    chk(v, 8'he0);
    timer_route_sel = 2'h2;
    cmp_raw = 1'b0;
    repeat (20) @(negedge clk);
    chk(8'(cap_a * 16 + cap_b), 8'h11);
    // Rise flag must survive the idle cycles
    rd(CMPONE_CTRL_ADDR, CMPONE_PAGE, v);
    chk(v, 8'hb0);
    wr(CMPONE_CTRL_ADDR, 8'h90, CMPONE_PAGE);
    chk({7'h00, cmp_irq}, 8'h00);
    wr(CMPONE_MODE_ADDR, 8'hb2, CMPONE_PAGE);
    chk({7'h00, cmp_irq}, 8'h01);
    rd(CMPONE_CTRL_ADDR, CMPONE_PAGE, v);
    chk(v, 8'h90);
    wr(CMPONE_CTRL_ADDR, 8'h80, CMPONE_PAGE);
    chk({7'h00, cmp_irq}, 8'h00);
    rd(CMPONE_CTRL_ADDR, CMPONE_PAGE, v);
    chk(v, 8'h80);
    $display("test edge done");
  endtask : t_edge
  task automatic t_race();
    // Software clear lands on the same edge as a new result edge
    @(negedge clk);
    cmp_raw = 1'b1;
    @(negedge clk);
    wr(CMPONE_CTRL_ADDR, 8'h80, CMPONE_PAGE);
    rd(CMPONE_CTRL_ADDR, CMPONE_PAGE, v);
    chk(v, 8'he0);
    cmp_raw = 1'b0;
    @(negedge clk);
    wr(CMPONE_CTRL_ADDR, 8'h80, CMPONE_PAGE);
    rd(CMPONE_CTRL_ADDR, CMPONE_PAGE, v);
    chk(v, 8'h90);
    chk({7'h00, cmp_irq}, 8'h01);
    wr(CMPONE_CTRL_ADDR, 8'h00, CMPONE_PAGE);
    rd(CMPONE_CTRL_ADDR, CMPONE_PAGE, v);
    chk(v, 8'h00);
    $display("test clear race done");
  endtask : t_race
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_hyst();
    t_mode();
    t_bad();
    t_edge();
    t_race();
    stop_test();
  end
endmodule : comparator_one_control_regs_tb
